// [design/fbod_host.sv]
// Host controller that drives an asynchronous 16-bit NOR flash through its bus pins.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R01: Reads hold chip select and output gate low, write strobe high; data captured.
// R02: Command writes pulse write strobe with chip select low, output gate high.
// R03: Device latches each command with address and data; host writes both together.
// R04: After reset the device reads array data with no command needed.
// R05: Device stays in array read until a written command changes its latch.
// R06: Page is 4 words; bits 2 and above pick page, bits 1:0 the word.
// R07: First page access waits full time; same-page follow-ups wait page time.
// R08: Shortened mode programs a word with two writes instead of four.
// R09: Buffered programming takes at most 16 words per operation.
// R10: Boost level enters shortened mode, lifts protection; removal restores normal.
// R11: Host applies boost only during accelerated programming requests.
// R12: Identifier reads return codes on the low eight data lines, normal timing.
// R13: Chip select and reset high put device in standby, outputs high impedance.
// R14: A read from standby waits the full select access time.
// R15: Deselecting during program or erase does not stop the operation.
// R16: Word address is 22 bits; sector is bits 21 to 15.
// R17: Erase targets a sector, a set of sectors, or the whole array.
// R18: Reset low for the pulse width aborts work and returns to array read.
// R19: Output gate high puts the device data lines in high impedance.
// R20: With chip select high the device ignores output gate and write strobe.

module fbod_host #(
    parameter int ADDR_W          = fbod_pkg::ADDR_W,
    parameter int DATA_W          = fbod_pkg::DATA_W,
    parameter int RAND_ACCESS_CYC = fbod_pkg::RAND_ACCESS_CYC,
    parameter int PAGE_ACCESS_CYC = fbod_pkg::PAGE_ACCESS_CYC,
    parameter int RST_CYC         = fbod_pkg::RST_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                reqValid,
    input  wire fbod_pkg::fbod_req_s req,
    output var  logic                reqReady,
    output var  logic                rspValid,
    output var  logic [DATA_W-1:0]   rspData,
    output var  logic [6:0]          rspSector,
    output var  fbod_pkg::fbod_pins_s pins,
    input  wire logic [DATA_W-1:0]   dataIn
);

    initial begin
        if (ADDR_W != fbod_pkg::ADDR_W || DATA_W != fbod_pkg::DATA_W)
            $error("fbod_host supports only a 22-bit address and 16-bit data");
        if (RAND_ACCESS_CYC < 1 || PAGE_ACCESS_CYC < 1 || RST_CYC < 1)
            $error("fbod_host timing counts must be at least one");
        if (RAND_ACCESS_CYC >= 64 || RST_CYC >= 64 || PAGE_ACCESS_CYC > RAND_ACCESS_CYC)
            $error("fbod_host timing counts out of range");
    end

    // ==========================================================================
    // State.
    typedef struct packed {
        fbod_pkg::fbod_state_e          st;
        logic [fbod_pkg::CNT_W-1:0]     cnt;
        logic                           pageValid;
        logic [ADDR_W-1:fbod_pkg::PAGE_LSB] pageTag;
        logic                           idMode;
        logic                           reqReady;
        logic                           rspValid;
        logic [DATA_W-1:0]              rspData;
        logic [6:0]                     rspSector;
        fbod_pkg::fbod_pins_s           pins;
    } fbod_state_s;

    fbod_state_s cur;
    fbod_state_s next_cur;
    logic        samePage;
    logic        take;

    assign samePage = cur.pageValid
        && (cur.pageTag == req.addr[ADDR_W-1:fbod_pkg::PAGE_LSB]); // R06
    assign take = reqValid && cur.reqReady;

    always_comb begin
        next_cur = cur;
        next_cur.rspValid = 1'b0;
        unique case (cur.st)
            fbod_pkg::FBOD_IDLE: begin
                // Park deselected so the device sits in standby between requests.
                next_cur.pins.chipSelN     = 1'b1; // R13
                next_cur.pins.outGateN     = 1'b1; // R19
                next_cur.pins.writeStrobeN = 1'b1; // R20
                next_cur.pins.boostOn      = 1'b0; // R11
                next_cur.pins.dataOe       = 1'b0;
                if (take) begin
                    next_cur.reqReady = 1'b0;
                    next_cur.pins.addr = req.addr; // R16 R17
                    unique case (req.op)
                        fbod_pkg::FBOD_OP_READ, fbod_pkg::FBOD_OP_IDREAD: begin
                            next_cur.pins.chipSelN = 1'b0; // R01
                            next_cur.pins.outGateN = 1'b0;
                            next_cur.idMode = (req.op == fbod_pkg::FBOD_OP_IDREAD); // R12
                            // Chip select drops here, so only a page hit on a kept
                            // selection could shorten it; from standby wait fully.
                            next_cur.cnt = fbod_pkg::CNT_W'(RAND_ACCESS_CYC); // R07 R14
                            next_cur.pageValid = 1'b1;
                            next_cur.pageTag = req.addr[ADDR_W-1:fbod_pkg::PAGE_LSB];
                            next_cur.st = fbod_pkg::FBOD_RDWAIT;
                        end
                        fbod_pkg::FBOD_OP_WRITE, fbod_pkg::FBOD_OP_ACCPROG: begin
                            next_cur.pins.chipSelN     = 1'b0; // R02
                            next_cur.pins.writeStrobeN = 1'b0;
                            // One word per strobe: buffered loads of up to BUF_WORDS words and
                            // sector, multi-sector or whole-array erases are series of writes.
                            next_cur.pins.dataOut      = req.wdata; // R03 R09 R17
                            next_cur.pins.dataOe       = 1'b1;
                            next_cur.pins.boostOn =
                                (req.op == fbod_pkg::FBOD_OP_ACCPROG); // R10 R11 R08
                            next_cur.pageValid = 1'b0; // R05
                            next_cur.cnt = fbod_pkg::CNT_W'(fbod_pkg::WR_PULSE_CYC);
                            next_cur.st = fbod_pkg::FBOD_WRLOW;
                        end
                        fbod_pkg::FBOD_OP_RESET: begin
                            next_cur.pins.resetN = 1'b0; // R18
                            next_cur.pageValid = 1'b0;
                            next_cur.idMode = 1'b0; // R04
                            next_cur.cnt = fbod_pkg::CNT_W'(RST_CYC);
                            next_cur.st = fbod_pkg::FBOD_RSTLOW;
                        end
                        default: begin
                            next_cur.reqReady = 1'b1;
                            next_cur.rspValid = 1'b1;
                            next_cur.rspData  = '0;
                        end
                    endcase
                end
            end
            fbod_pkg::FBOD_RDWAIT: begin
                if (cur.cnt > fbod_pkg::CNT_W'(1)) begin
                    next_cur.cnt = cur.cnt - fbod_pkg::CNT_W'(1);
                end else if (reqValid && samePage && !cur.idMode
                        && req.op == fbod_pkg::FBOD_OP_READ) begin
                    // Capture and chain a same-page read with chip select held.
                    next_cur.rspValid = 1'b1;
                    next_cur.rspData = dataIn;
                    next_cur.rspSector = cur.pins.addr[ADDR_W-1:fbod_pkg::SECTOR_LSB];
                    next_cur.pins.addr = req.addr;
                    next_cur.cnt = fbod_pkg::CNT_W'(PAGE_ACCESS_CYC); // R07
                end else begin
                    next_cur.rspValid = 1'b1;
                    next_cur.rspData = cur.idMode
                        ? {{(DATA_W-fbod_pkg::ID_W){1'b0}}, dataIn[fbod_pkg::ID_W-1:0]} // R12
                        : dataIn; // R01
                    next_cur.rspSector = cur.pins.addr[ADDR_W-1:fbod_pkg::SECTOR_LSB]; // R16
                    next_cur.pins.chipSelN = 1'b1;
                    next_cur.pins.outGateN = 1'b1;
                    next_cur.reqReady = 1'b1;
                    next_cur.st = fbod_pkg::FBOD_IDLE;
                end
            end
            fbod_pkg::FBOD_WRLOW: begin
                if (cur.cnt > fbod_pkg::CNT_W'(1)) begin
                    next_cur.cnt = cur.cnt - fbod_pkg::CNT_W'(1);
                end else begin
                    // The device latches on the rising strobe; hold data one more cycle.
                    next_cur.pins.writeStrobeN = 1'b1; // R02
                    next_cur.st = fbod_pkg::FBOD_WRHIGH;
                end
            end
            fbod_pkg::FBOD_WRHIGH: begin
                // Deselect even if an erase runs on; the device completes it. R15
                next_cur.pins.chipSelN = 1'b1;
                next_cur.pins.dataOe   = 1'b0;
                // Drop the boost level as soon as the strobe cycle is over.
                next_cur.pins.boostOn  = 1'b0; // R11
                next_cur.rspValid      = 1'b1;
                next_cur.rspData       = '0;
                next_cur.reqReady      = 1'b1;
                next_cur.st = fbod_pkg::FBOD_IDLE;
            end
            fbod_pkg::FBOD_RSTLOW: begin
                if (cur.cnt > fbod_pkg::CNT_W'(1)) begin
                    next_cur.cnt = cur.cnt - fbod_pkg::CNT_W'(1);
                end else begin
                    // The pulse has lasted its full width; release and wait for recovery.
                    next_cur.pins.resetN = 1'b1; // R18
                    next_cur.cnt = fbod_pkg::CNT_W'(fbod_pkg::RST_HOLD_CYC);
                    next_cur.st = fbod_pkg::FBOD_RSTREC;
                end
            end
            fbod_pkg::FBOD_RSTREC: begin
                if (cur.cnt > fbod_pkg::CNT_W'(1)) begin
                    next_cur.cnt = cur.cnt - fbod_pkg::CNT_W'(1);
                end else begin
                    next_cur.rspValid = 1'b1;
                    next_cur.rspData  = '0;
                    next_cur.reqReady = 1'b1;
                    next_cur.st = fbod_pkg::FBOD_IDLE;
                end
            end
            default: begin
                next_cur.st = fbod_pkg::FBOD_IDLE;
                next_cur.reqReady = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur.st <= fbod_pkg::FBOD_IDLE;
            cur.reqReady <= 1'b1;
            cur.pins.chipSelN <= 1'b1;
            cur.pins.outGateN <= 1'b1;
            cur.pins.writeStrobeN <= 1'b1;
            cur.pins.resetN <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign reqReady  = cur.reqReady;
    assign rspValid  = cur.rspValid;
    assign rspData   = cur.rspData;
    assign rspSector = cur.rspSector;
    assign pins      = cur.pins;

endmodule
`default_nettype wire

// [design/fbod_pkg.sv]
// Package of constants, types and timing counts for the flash bus operation host controller.
package fbod_pkg;

    // ==========================================================================
    // Geometry.
    localparam int ADDR_W       = 22;
    localparam int DATA_W       = 16;
    localparam int PAGE_LSB     = 2;
    localparam int SECTOR_LSB   = 15;
    localparam int BUF_WORDS    = 16;
    localparam int ID_W         = 8;

    // ==========================================================================
    // Timing, figures in ns at a 20 ns clock.
    localparam int CLK_NS       = 20;
    localparam int RAND_ACCESS_NS = 90;
    localparam int PAGE_ACCESS_NS = 25;
    localparam int WR_PULSE_NS  = 35;
    localparam int RST_PULSE_NS = 500;
    localparam int RST_HOLD_NS  = 50;
    localparam int RAND_ACCESS_CYC = (RAND_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAGE_ACCESS_CYC = (PAGE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC      = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W        = 6;

    // ==========================================================================
    // Request kinds from the user side.
    typedef enum logic [2:0] {
        FBOD_OP_READ    = 3'h0,
        FBOD_OP_WRITE   = 3'h1,
        FBOD_OP_ACCPROG = 3'h2,
        FBOD_OP_RESET   = 3'h3,
        FBOD_OP_IDREAD  = 3'h4
    } fbod_op_e;

    typedef enum logic [2:0] {
        FBOD_IDLE   = 3'b000,
        FBOD_RDWAIT = 3'b001,
        FBOD_WRLOW  = 3'b011,
        FBOD_WRHIGH = 3'b010,
        FBOD_RSTLOW = 3'b110,
        FBOD_RSTREC = 3'b111
    } fbod_state_e;

    typedef struct packed {
        fbod_op_e            op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } fbod_req_s;

    typedef struct packed {
        logic                chipSelN;
        logic                outGateN;
        logic                writeStrobeN;
        logic                resetN;
        logic                boostOn;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dataOut;
        logic                dataOe;
    } fbod_pins_s;

endpackage

// [tb/fbod_host_asserts.sv]
// Port checker for the flash bus host controller.
`timescale 1ns/10ps
`default_nettype none
module fbod_host_asserts #(
    parameter int RAND_ACCESS_CYC = 5,
    parameter int PAGE_ACCESS_CYC = 2,
    parameter int RST_CYC         = 25
) (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 reqValid,
    input wire fbod_pkg::fbod_req_s  req,
    input wire logic                 reqReady,
    input wire logic                 rspValid,
    input wire logic [15:0]          rspData,
    input wire logic [6:0]           rspSector,
    input wire fbod_pkg::fbod_pins_s pins,
    input wire logic [15:0]          dataIn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic rd;
    logic boostTake;
    logic [6:0] reqSector;
    assign take = reqValid && reqReady;
    assign rd   = take && req.op == fbod_pkg::FBOD_OP_READ;
    assign boostTake = take && req.op == fbod_pkg::FBOD_OP_ACCPROG;
    assign reqSector = req.addr[21:15];
    property p_rdPins;
        rd |=> !pins.chipSelN && !pins.outGateN && pins.writeStrobeN && !pins.dataOe;
    endproperty
    a_rdPins: assert property (p_rdPins) else $error("read strobes wrong");
    property p_rdTime;
        rd |=> !rspValid [*5] ##1 rspValid;
    endproperty
    a_rdTime: assert property (p_rdTime) else $error("read answer time wrong");
    property p_sector;
        rd |-> ##6 rspSector == $past(reqSector, 6);
    endproperty
    a_sector: assert property (p_sector) else $error("sector field wrong");
    property p_wrPins;
        take && req.op == fbod_pkg::FBOD_OP_WRITE |=> !pins.chipSelN && !pins.writeStrobeN
            && pins.outGateN && pins.dataOe && pins.dataOut == $past(req.wdata);
    endproperty
    a_wrPins: assert property (p_wrPins) else $error("write strobes wrong");
    property p_wrTime;
        take && req.op == fbod_pkg::FBOD_OP_WRITE |-> ##4 rspValid && pins.chipSelN;
    endproperty
    a_wrTime: assert property (p_wrTime) else $error("write end wrong");
    property p_boostCause;
        $rose(pins.boostOn) |-> $past(boostTake);
    endproperty
    a_boostCause: assert property (p_boostCause) else $error("boost without program");
    property p_boostWr;
        pins.boostOn |-> pins.outGateN && pins.resetN;
    endproperty
    a_boostWr: assert property (p_boostWr) else $error("boost during read");
    property p_rstLow;
        take && req.op == fbod_pkg::FBOD_OP_RESET |=> !pins.resetN [*8];
    endproperty
    a_rstLow: assert property (p_rstLow) else $error("reset pulse short");
    property p_rstTime;
        take && req.op == fbod_pkg::FBOD_OP_RESET |-> ##29 rspValid && pins.resetN;
    endproperty
    a_rstTime: assert property (p_rstTime) else $error("reset end wrong");
    property p_noFight;
        !pins.outGateN |-> !pins.dataOe;
    endproperty
    a_noFight: assert property (p_noFight) else $error("drive while output on");
    property p_pageTime;
        rspValid && !pins.chipSelN |=> !rspValid ##1 rspValid;
    endproperty
    a_pageTime: assert property (p_pageTime) else $error("page access time wrong");
    c_read: cover property (rd);
    c_accel: cover property (pins.boostOn && !pins.writeStrobeN);
    c_reset: cover property (!pins.resetN);
    c_chain: cover property (rspValid && !pins.chipSelN);
endmodule
bind fbod_host fbod_host_asserts #(
    .RAND_ACCESS_CYC(RAND_ACCESS_CYC),
    .PAGE_ACCESS_CYC(PAGE_ACCESS_CYC),
    .RST_CYC(RST_CYC)
) i_fbod_host_asserts (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspSector(rspSector),
    .pins(pins), .dataIn(dataIn));
`default_nettype wire

// [tb/fbod_flash_model.sv]
// Behavioural model of the flash device on the host's pins.
`timescale 1ns/10ps
`default_nettype none
module fbod_flash_model #(
    parameter logic [7:0] ID_CODE = 8'h3c, // Arbitrary identifier value.
    parameter logic [7:0] ID_CMD  = 8'h90
) (
    input wire logic                 clk,
    input wire fbod_pkg::fbod_pins_s pins,
    output logic [15:0]              dataIn,
    output logic                     boostSeen
);
    logic        idMode = 1'b0;
    logic        lastWe = 1'b1;
    logic [21:0] cmdAddr = '0;
    logic [15:0] cmdData = '0;
    logic [15:0] lastOut = '0;
    logic [2:0]  selCnt = '0;
    initial boostSeen = 1'b0;
    always @(posedge clk) begin
        lastWe <= pins.writeStrobeN;
        lastOut <= dataIn;
        selCnt <= (pins.chipSelN || pins.outGateN) ? 3'h0 : selCnt + {2'h0, selCnt != 3'h7};
        if (!pins.resetN) begin
            idMode <= 1'b0;
        end else if (!pins.chipSelN && pins.writeStrobeN && !lastWe) begin
            cmdAddr <= pins.addr;
            cmdData <= pins.dataOut;
            idMode <= pins.dataOut[7:0] == ID_CMD;
            boostSeen <= boostSeen | pins.boostOn;
        end
    end
    // Deselected or disabled outputs toggle so that stale data never looks valid.
    always_comb begin
        if (!pins.resetN || pins.chipSelN || pins.outGateN || selCnt < 3'h2) begin
            dataIn = ~lastOut;
        end else if (idMode) begin
            dataIn = {~ID_CODE, ID_CODE};
        end else begin
            dataIn = pins.addr[15:0] ^ 16'h5a5a;
        end
    end
endmodule
`default_nettype wire

// [tb/flash_bus_operation_decode_tb_top.sv]
// Self-checking testbench of the flash bus host controller.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_operation_decode_tb_top;
    logic                 clk = 1'b0;
    logic                 rst_n;
    logic                 reqValid;
    fbod_pkg::fbod_req_s  req;
    logic                 reqReady;
    logic                 rspValid;
    logic [15:0]          rspData;
    logic [6:0]           rspSector;
    fbod_pkg::fbod_pins_s pins;
    logic [15:0]          dataIn;
    logic                 boostSeen;
    int                   n_errors = 0;
    int                   checks_done = 0;
    int                   cycles = 0;
    int                   waitCycles = 0;
    always #10 clk = ~clk;
    fbod_host i_fbod_host (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .rspSector(rspSector), .pins(pins), .dataIn(dataIn));
    fbod_flash_model i_fbod_flash_model (.clk(clk), .pins(pins), .dataIn(dataIn),
        .boostSeen(boostSeen));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("Checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_op(input fbod_pkg::fbod_op_e op, input logic [21:0] a,
                         input logic [15:0] d);
        int n;
        @(posedge clk);
        reqValid <= 1'b1;
        req <= '{op, a, d};
        @(posedge clk);
        reqValid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!rspValid && n < 40);
        waitCycles = n;
        check("rspValid", rspValid, 1);
    endtask
    task automatic t_chain();
        int n;
        @(posedge clk);
        reqValid <= 1'b1;
        req <= '{fbod_pkg::FBOD_OP_READ, 22'h000104, 16'h0};
        @(posedge clk);
        req <= '{fbod_pkg::FBOD_OP_READ, 22'h000106, 16'h0};
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!rspValid && n < 40);
        check("firstTime", n, fbod_pkg::RAND_ACCESS_CYC);
        check("firstWord", rspData, 16'h5b5e);
        check("held", pins.chipSelN, 0);
        n = 0;
        do begin
            @(posedge clk);
            reqValid <= 1'b0;
            #1;
            n++;
        end while (!rspValid && n < 40);
        check("pageTime", n, fbod_pkg::PAGE_ACCESS_CYC);
        check("pageWord", rspData, 16'h5b5c);
        check("released", reqReady, 1);
    endtask
    task automatic t_pages();
        logic [21:0] a;
        for (int i = 0; i < 4; i++) begin
            a = 22'h107ffe + 22'(i);
            do_op(fbod_pkg::FBOD_OP_READ, a, 16'h0);
            check("readTime", waitCycles, fbod_pkg::RAND_ACCESS_CYC);
            check("array", rspData, a[15:0] ^ 16'h5a5a);
            check("sector", rspSector, a[21:15]);
        end
    endtask
    task automatic t_ident();
        do_op(fbod_pkg::FBOD_OP_WRITE, 22'h000555, 16'h0090);
        check("wrTime", waitCycles, fbod_pkg::WR_PULSE_CYC + 1);
        check("cmdAddr", i_fbod_flash_model.cmdAddr, 22'h000555);
        check("cmdData", i_fbod_flash_model.cmdData, 16'h0090);
        do_op(fbod_pkg::FBOD_OP_IDREAD, 22'h000001, 16'h0);
        check("ident", rspData, 16'h003c);
        do_op(fbod_pkg::FBOD_OP_READ, 22'h000002, 16'h0);
        check("stay", rspData, 16'hc33c);
        do_op(fbod_pkg::FBOD_OP_RESET, 22'h0, 16'h0);
        check("rstTime", waitCycles, fbod_pkg::RST_CYC + fbod_pkg::RST_HOLD_CYC);
        do_op(fbod_pkg::FBOD_OP_READ, 22'h000002, 16'h0);
        check("back", rspData, 16'h5a58);
    endtask
    task automatic t_accel();
        check("noBoost", boostSeen, 0);
        do_op(fbod_pkg::FBOD_OP_ACCPROG, 22'h2a0100, 16'h1234);
        check("boost", boostSeen, 1);
        @(posedge clk);
        #1;
        check("boostOff", pins.boostOn, 0);
        check("idle", pins.chipSelN, 1);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        reqValid = 1'b0;
        req = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("ready", reqReady, 1);
        check("resetPin", pins.resetN, 1);
        check("dataOe", pins.dataOe, 0);
        t_pages();
        t_chain();
        t_ident();
        t_accel();
        results();
    end
endmodule
`default_nettype wire
